// >>> include/agu_cfg.svh
// Address map, field positions and fixed values of the address generation unit
`ifndef AGU_CFG_SVH
`define AGU_CFG_SVH
`define AGU_OFF_CTRL    8'h00
`define AGU_OFF_XSTART  8'h04
`define AGU_OFF_XEND    8'h08
`define AGU_OFF_YSTART  8'h0C
`define AGU_OFF_YEND    8'h10
`define AGU_OFF_SPLIMIT 8'h14
`define AGU_OFF_SP      8'h18
`define AGU_CTRL_RST    16'h0000
`define AGU_BOUND_RST   16'h0000
`define AGU_XEN_BIT     15
`define AGU_YEN_BIT     14
`define AGU_XSEL_HI     3
`define AGU_XSEL_LO     0
`define AGU_YSEL_HI     7
`define AGU_YSEL_LO     4
`define AGU_SEL_OFF     4'hF
`define AGU_SP_IDX      4'hF
`define AGU_W0_IDX      4'h0
`define AGU_W8_IDX      4'h8
`define AGU_W9_IDX      4'h9
`define AGU_W10_IDX     4'hA
`define AGU_W11_IDX     4'hB
`define AGU_SFR_TOP     16'h0800
`define AGU_WORD_STEP   16'h0002
`define AGU_NEG_STEP    16'hFFFE
`define AGU_MOD2        16'h0002
`define AGU_MOD4        16'h0004
`define AGU_MOD6        16'h0006
`define AGU_ZERO16      16'h0000
`endif

// >>> include/agu_pkg.sv
// Types shared by the address generation unit and its users
package agu_pkg;
  typedef enum logic [2:0] {
    MODE_INDIRECT,
    MODE_POST,
    MODE_PRE,
    MODE_REG_OFF,
    MODE_LIT_OFF,
    MODE_FILE
  } agu_mode_t;
  typedef enum logic [1:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP
  } agu_stack_t;
  typedef enum logic [1:0] {
    PUSH_DATA,
    PUSH_CALL_HI,
    PUSH_EXC_HI
  } agu_push_t;
endpackage

// >>> logic/agu_addr_gen.sv
// Data address generator with software stack and circular buffer correction
// Operation
// - W15 stack pointer, post-inc push, pre-dec pop
// - Call pushes PC with MSb cleared
// - Exception push joins status byte to PC
// - Stack limit bit 0 zero, no reset
// - Compare stack pointer addresses with limit
// - Push at limit ok, next push traps
// - Stack address below 0x0800 traps
// - File register 13-bit address, dest W0
// - Operand one direct, two register or literal
// - Indirect, post, pre, register, literal offset
// - One shared offset field for move
// - W8/W9 to X, W10/W11 to Y
// - MAC: indirect, post 2/4/6, indexed only
// - Branch 16-bit signed, disable 14-bit literal
// - One circular buffer per X and Y
// - Both boundaries checked for circular buffers
// - 16-bit start and end bound registers
// - Y circular addresses keep LSb clear
// - X circular needs enable 15, select not 15
// - Y circular needs enable 14, select not 15
// - Bounds detect beyond, not only equal
// - Write back corrected pointer only on modify
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "agu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module agu_addr_gen
  import agu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        req_i,
  input  wire agu_mode_t   mode_i,
  input  wire logic [3:0]  ptr_i,
  input  wire logic [3:0]  off_reg_i,
  input  wire logic [15:0] lit_i,
  input  wire logic        mac_i,
  input  wire logic        y_space_i,
  input  wire logic        dst_w0_i,
  input  wire agu_stack_t  stack_op_i,
  input  wire agu_push_t   push_kind_i,
  input  wire logic [15:0] push_data_i,
  input  wire logic [22:0] pc_i,
  input  wire logic [7:0]  status_low_byte_i,
  input  wire logic [3:0]  base_operand_reg_i,
  input  wire logic        op2_lit_i,
  input  wire logic [4:0]  lit5_i,
  input  wire logic [15:0] branch_lit_i,
  input  wire logic [13:0] interrupt_disable_instr_lit_i,
  input  wire logic        default_working_reg_we_i,
  input  wire logic [3:0]  default_working_reg_idx_i,
  input  wire logic [15:0] default_working_reg_data_i,
  output logic             ea_valid_o,
  output logic      [15:0] ea_o,
  output logic             ea_y_space_o,
  output logic             dst_w0_o,
  output logic      [15:0] push_word_o,
  output logic      [15:0] op1_o,
  output logic      [15:0] op2_o,
  output logic      [15:0] branch_off_o,
  output logic      [13:0] interrupt_disable_instr_count_o,
  output logic             mac_illegal_o,
  output logic             stack_error_o,
  output logic      [15:0] stack_pointer_reg_o
);

  logic [15:0] default_working_reg [16];
  logic [15:0] circular_addr_control;
  logic [15:0] x_buffer_start;
  logic [15:0] x_buffer_end;
  logic [15:0] y_buffer_start;
  logic [15:0] y_buffer_end;
  logic [15:0] stack_limit;

  // APB decode
  wire         apb_setup  = psel_i & ~penable_i;
  wire         apb_access = psel_i & penable_i;
  wire         hit_ctrl   = paddr_i == `AGU_OFF_CTRL;
  wire         hit_xs     = paddr_i == `AGU_OFF_XSTART;
  wire         hit_xe     = paddr_i == `AGU_OFF_XEND;
  wire         hit_ys     = paddr_i == `AGU_OFF_YSTART;
  wire         hit_ye     = paddr_i == `AGU_OFF_YEND;
  wire         hit_lim    = paddr_i == `AGU_OFF_SPLIMIT;
  wire         hit_sp     = paddr_i == `AGU_OFF_SP;
  wire         addr_hit   = hit_ctrl | hit_xs | hit_xe | hit_ys | hit_ye | hit_lim | hit_sp;
  wire         apb_wr     = apb_access & pwrite_i & addr_hit;
  wire [15:0]  rd_word    = hit_ctrl ? circular_addr_control :
                            hit_xs   ? x_buffer_start :
                            hit_xe   ? x_buffer_end :
                            hit_ys   ? y_buffer_start :
                            hit_ye   ? y_buffer_end :
                            hit_lim  ? stack_limit :
                            hit_sp   ? default_working_reg[`AGU_SP_IDX] : `AGU_ZERO16;

  assign pready_o  = 1'b1;
  assign pslverr_o = apb_access & ~addr_hit;

  // Stack operations override the decoder's pointer and mode
  wire         is_push   = stack_op_i == STK_PUSH;
  wire         is_pop    = stack_op_i == STK_POP;
  wire         is_stack  = is_push | is_pop;
  wire [3:0]   eff_ptr   = is_stack ? `AGU_SP_IDX : ptr_i;
  agu_mode_t   eff_mode;
  always_comb begin
    case (stack_op_i)
      STK_PUSH: eff_mode = MODE_POST;
      STK_POP:  eff_mode = MODE_PRE;
      default:  eff_mode = mode_i;
    endcase
  end
  wire [15:0]  eff_mod   = is_push ? `AGU_WORD_STEP :
                           is_pop  ? `AGU_NEG_STEP : lit_i;
  wire         eff_mac   = mac_i & ~is_stack;

  // Move uses one offset index for source and destination alike
  wire [15:0]  base      = default_working_reg[eff_ptr];
  wire [15:0]  offv      = default_working_reg[off_reg_i];

  // Multiply-accumulate operand checks
  wire         mac_ptr_ok = eff_ptr == `AGU_W8_IDX || eff_ptr == `AGU_W9_IDX ||
                            eff_ptr == `AGU_W10_IDX || eff_ptr == `AGU_W11_IDX;
  wire         mac_mod_ok = eff_mod == `AGU_MOD2 || eff_mod == `AGU_MOD4 ||
                            eff_mod == `AGU_MOD6;
  wire         mac_idx_ok = eff_ptr == `AGU_W9_IDX || eff_ptr == `AGU_W11_IDX;
  wire         mac_mode_ok = (eff_mode == MODE_INDIRECT) |
                             (eff_mode == MODE_POST & mac_mod_ok) |
                             (eff_mode == MODE_REG_OFF & mac_idx_ok);
  wire         mac_ok     = mac_ptr_ok & mac_mode_ok;
  wire         active     = req_i | is_stack;
  wire         go         = active & (~eff_mac | mac_ok);

  // W8/W9 go to X, W10/W11 go to Y
  wire         use_y      = eff_mac ? (eff_ptr >= `AGU_W10_IDX) : y_space_i;

  // Raw effective address per mode
  logic [15:0] raw_ea;
  always_comb begin
    case (eff_mode)
      MODE_INDIRECT: raw_ea = base;
      MODE_POST:     raw_ea = base;
      MODE_PRE:      raw_ea = base + eff_mod;
      MODE_REG_OFF:  raw_ea = base + offv;
      MODE_LIT_OFF:  raw_ea = base + lit_i;
      MODE_FILE:     raw_ea = {3'b000, lit_i[12:0]};
      default:       raw_ea = base;
    endcase
  end

  wire         is_mod_mode = eff_mode == MODE_POST | eff_mode == MODE_PRE;
  wire [15:0]  post_ptr    = base + eff_mod;

  // Circular enables; select of 15 turns each generator off
  wire [3:0]   x_sel  = circular_addr_control[`AGU_XSEL_HI:`AGU_XSEL_LO];
  wire [3:0]   y_sel  = circular_addr_control[`AGU_YSEL_HI:`AGU_YSEL_LO];
  wire         x_on   = circular_addr_control[`AGU_XEN_BIT] & (x_sel != `AGU_SEL_OFF);
  wire         y_on   = circular_addr_control[`AGU_YEN_BIT] & (y_sel != `AGU_SEL_OFF);
  wire         not_file = eff_mode != MODE_FILE;
  wire         x_act  = x_on & ~use_y & not_file & (eff_ptr == x_sel);
  wire         y_act  = y_on & use_y & not_file & (eff_ptr == y_sel);

  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] x_post;
  logic [15:0] y_post;

  // Access address and updated pointer are corrected separately
  agu_wrap u_x_ea (
    .addr_i (raw_ea),
    .lo_i   (x_buffer_start),
    .hi_i   (x_buffer_end),
    .addr_o (x_ea)
  );

  agu_wrap u_y_ea (
    .addr_i (raw_ea),
    .lo_i   (y_buffer_start),
    .hi_i   (y_buffer_end),
    .addr_o (y_ea)
  );

  agu_wrap u_x_post (
    .addr_i (post_ptr),
    .lo_i   (x_buffer_start),
    .hi_i   (x_buffer_end),
    .addr_o (x_post)
  );

  agu_wrap u_y_post (
    .addr_i (post_ptr),
    .lo_i   (y_buffer_start),
    .hi_i   (y_buffer_end),
    .addr_o (y_post)
  );

  wire [15:0]  fix_ea = x_act ? x_ea :
                        y_act ? {y_ea[15:1], 1'b0} : raw_ea;
  wire [15:0]  fix_post = x_act ? x_post :
                          y_act ? {y_post[15:1], 1'b0} : post_ptr;

  // Offset modes correct the access only; modify modes update the pointer
  wire         wb_en  = go & is_mod_mode;
  wire [15:0]  wb_val = (eff_mode == MODE_POST) ? fix_post : fix_ea;

  // Any access through the stack pointer is checked against both ends
  wire         uses_sp  = not_file & (eff_ptr == `AGU_SP_IDX);
  wire         over_lim = fix_ea > stack_limit;
  wire         under_sfr = fix_ea < `AGU_SFR_TOP;
  wire         stk_err  = go & uses_sp & (over_lim | under_sfr);

  // Word placed on the stack
  logic [15:0] push_word;
  always_comb begin
    case (push_kind_i)
      PUSH_DATA:    push_word = push_data_i;
      PUSH_CALL_HI: push_word = {9'h000, pc_i[22:16]};
      PUSH_EXC_HI:  push_word = {status_low_byte_i, 1'b0, pc_i[22:16]};
      default:      push_word = push_data_i;
    endcase
  end

  // Three-operand sources
  wire [15:0]  op1_val = default_working_reg[base_operand_reg_i];
  wire [15:0]  op2_val = op2_lit_i ? {11'h000, lit5_i} : default_working_reg[ptr_i];
  wire [15:0]  br_val  = branch_lit_i;
  wire [13:0]  interrupt_disable_instr_val = interrupt_disable_instr_lit_i;

  // Working registers; a pointer update wins over a same-cycle ALU write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 16; i++) begin
        default_working_reg[i] <= `AGU_ZERO16;
      end
    end else begin
      if (default_working_reg_we_i) begin
        default_working_reg[default_working_reg_idx_i] <= default_working_reg_data_i;
      end
      if (wb_en) begin
        default_working_reg[eff_ptr] <= wb_val;
      end
    end
  end

  // Control and bound registers; the stack pointer offset is read-only
  wire         wr_ctrl = apb_wr & hit_ctrl;
  wire         wr_xs   = apb_wr & hit_xs;
  wire         wr_xe   = apb_wr & hit_xe;
  wire         wr_ys   = apb_wr & hit_ys;
  wire         wr_ye   = apb_wr & hit_ye;

  agu_reg16 #(.RST_VAL(`AGU_CTRL_RST)) u_ctrl (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (wr_ctrl),
    .d_i       (pwdata_i[15:0]),
    .q_o       (circular_addr_control)
  );

  agu_reg16 #(.RST_VAL(`AGU_BOUND_RST)) u_xs (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (wr_xs),
    .d_i       (pwdata_i[15:0]),
    .q_o       (x_buffer_start)
  );

  agu_reg16 #(.RST_VAL(`AGU_BOUND_RST)) u_xe (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (wr_xe),
    .d_i       (pwdata_i[15:0]),
    .q_o       (x_buffer_end)
  );

  agu_reg16 #(.RST_VAL(`AGU_BOUND_RST)) u_ys (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (wr_ys),
    .d_i       (pwdata_i[15:0]),
    .q_o       (y_buffer_start)
  );

  agu_reg16 #(.RST_VAL(`AGU_BOUND_RST)) u_ye (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (wr_ye),
    .d_i       (pwdata_i[15:0]),
    .q_o       (y_buffer_end)
  );

  // Limit has no reset value; software must load it before use
  always_ff @(posedge clk_i) begin
    if (apb_wr & hit_lim) begin
      stack_limit <= {pwdata_i[15:1], 1'b0};
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_o <= {16'h0000, rd_word};
    end
  end

  // Registered answer to the decoder, one cycle after the request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ea_valid_o    <= 1'b0;
      ea_o          <= `AGU_ZERO16;
      ea_y_space_o  <= 1'b0;
      dst_w0_o      <= 1'b0;
      push_word_o   <= `AGU_ZERO16;
      op1_o         <= `AGU_ZERO16;
      op2_o         <= `AGU_ZERO16;
      branch_off_o  <= `AGU_ZERO16;
      interrupt_disable_instr_count_o  <= 14'h0000;
      mac_illegal_o <= 1'b0;
      stack_error_o <= 1'b0;
    end else begin
      ea_valid_o    <= go;
      ea_o          <= fix_ea;
      ea_y_space_o  <= use_y;
      dst_w0_o      <= req_i & (mode_i == MODE_FILE) & dst_w0_i;
      push_word_o   <= push_word;
      op1_o         <= op1_val;
      op2_o         <= op2_val;
      branch_off_o  <= br_val;
      interrupt_disable_instr_count_o  <= interrupt_disable_instr_val;
      mac_illegal_o <= active & eff_mac & ~mac_ok;
      stack_error_o <= stk_err;
    end
  end

  assign stack_pointer_reg_o = default_working_reg[`AGU_SP_IDX];

endmodule // agu_addr_gen

// Circular correction of one address against one buffer; both bounds
// are checked, so a step that overshoots either one is folded back
module agu_wrap (
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] lo_i,
  input  wire logic [15:0] hi_i,
  output logic      [15:0] addr_o
);
  wire [15:0] len   = hi_i - lo_i + `AGU_WORD_STEP;
  wire        above = addr_i > hi_i;
  wire        below = addr_i < lo_i;
  assign addr_o = above ? addr_i - len :
                  below ? addr_i + len : addr_i;
endmodule // agu_wrap

// Sixteen-bit software register with write enable and reset value
module agu_reg16 #(
  parameter logic [15:0] RST_VAL = `AGU_ZERO16
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        we_i,
  input  wire logic [15:0] d_i,
  output logic      [15:0] q_o
);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_o <= RST_VAL;
    end else if (we_i) begin
      q_o <= d_i;
    end
  end
endmodule // agu_reg16
`default_nettype wire

// >>> testbench/agu_addr_gen_properties.sv
// Concurrent checks on the ports of the address generation unit
`timescale 1ns/100ps
`default_nettype none
module agu_addr_gen_properties
  import agu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_i,
  input wire agu_mode_t   mode_i,
  input wire logic [3:0]  ptr_i,
  input wire logic [15:0] lit_i,
  input wire logic        mac_i,
  input wire agu_stack_t  stack_op_i,
  input wire agu_push_t   push_kind_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0]  status_low_byte_i,
  input wire logic        op2_lit_i,
  input wire logic [4:0]  lit5_i,
  input wire logic [15:0] branch_lit_i,
  input wire logic [13:0] interrupt_disable_instr_lit_i,
  input wire logic        dst_w0_i,
  input wire logic        ea_valid_o,
  input wire logic [15:0] ea_o,
  input wire logic        dst_w0_o,
  input wire logic [15:0] push_word_o,
  input wire logic [15:0] op2_o,
  input wire logic [15:0] branch_off_o,
  input wire logic [13:0] interrupt_disable_instr_count_o,
  input wire logic        mac_illegal_o,
  input wire logic        stack_error_o,
  input wire logic [15:0] stack_pointer_reg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire plain_w = req_i && stack_op_i == STK_NONE;
  sequence s_push;
    stack_op_i == STK_PUSH;
  endsequence
  sequence s_push_ans;
    ea_valid_o && ea_o == $past(stack_pointer_reg_o)
      ##0 stack_pointer_reg_o == $past(stack_pointer_reg_o) + 16'h0002;
  endsequence
  a_push_post_inc: assert property (s_push |=> s_push_ans)
    else $error("push address or pointer step wrong");
  a_pop_pre_dec: assert property (stack_op_i == STK_POP |=> ea_valid_o &&
    ea_o == $past(stack_pointer_reg_o) - 16'h0002 && stack_pointer_reg_o == ea_o)
    else $error("pop address or pointer step wrong");
  a_call_msb_clear: assert property (s_push ##0 push_kind_i == PUSH_CALL_HI |=>
    push_word_o == {9'h000, $past(pc_i[22:16])}) else $error("call push word wrong");
  a_exc_status_join: assert property (s_push ##0 push_kind_i == PUSH_EXC_HI |=>
    push_word_o == {$past(status_low_byte_i), 1'h0, $past(pc_i[22:16])})
    else $error("exception push word wrong");
  a_stack_underflow: assert property (s_push ##0 stack_pointer_reg_o < 16'h0800
    |=> stack_error_o) else $error("underflow not flagged");
  a_error_with_addr: assert property (stack_error_o |-> ea_valid_o)
    else $error("stack error without address");
  a_file_direct: assert property (plain_w && mode_i == MODE_FILE |=> ea_valid_o &&
    ea_o == {3'h0, $past(lit_i[12:0])} && dst_w0_o == $past(dst_w0_i))
    else $error("file register address wrong");
  a_mac_refused: assert property (plain_w && mac_i && ptr_i < 4'h8
    |=> mac_illegal_o && !ea_valid_o) else $error("illegal prefetch accepted");
  a_literal_fields: assert property (1'h1 |=> branch_off_o == $past(branch_lit_i) &&
    interrupt_disable_instr_count_o == $past(interrupt_disable_instr_lit_i)) else $error("literal field wrong");
  a_op2_literal: assert property (op2_lit_i |=> op2_o == {11'h000, $past(lit5_i)})
    else $error("second operand literal wrong");
endmodule // agu_addr_gen_properties
bind agu_addr_gen agu_addr_gen_properties u_props (.*);
`default_nettype wire

// >>> testbench/agu_mem_model.sv
// Data memory model that keeps pushed words for read-back
`timescale 1ns/100ps
`default_nettype none
module agu_mem_model (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] raddr_i,
  output logic      [15:0] rdata_o
);
  // Only 256 words are kept, aliased; enough for the stack frames used
  logic [15:0] mem [0:255];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i[8:1]] <= wdata_i;
    end
  end
  assign rdata_o = mem[raddr_i[8:1]];
endmodule // agu_mem_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking testbench for the address generation unit
`include "agu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import agu_pkg::*;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic req_i = 1'h0, mac_i = 1'h0, y_space_i = 1'h0, dst_w0_i = 1'h1, op2_lit_i = 1'h1;
  logic default_working_reg_we_i = 1'h0, err, push_q = 1'h0;
  logic pready_o, pslverr_o, ea_valid_o, ea_y_space_o, dst_w0_o, mac_illegal_o, stack_error_o;
  logic [7:0] paddr_i = 8'h00, status_low_byte_i = 8'hA5;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] ptr_i = 4'h0, off_reg_i = 4'h0, base_operand_reg_i = 4'h0, default_working_reg_idx_i = 4'h0;
  logic [15:0] lit_i = 16'h0, push_data_i = 16'h0, branch_lit_i = 16'h0, default_working_reg_data_i = 16'h0;
  logic [15:0] ea_o, push_word_o, op1_o, op2_o, branch_off_o, stack_pointer_reg_o, mem_q;
  logic [15:0] maddr = 16'h0;
  logic [4:0] lit5_i = 5'h00;
  logic [13:0] interrupt_disable_instr_lit_i = 14'h0, interrupt_disable_instr_count_o;
  logic [22:0] pc_i = 23'h7FFFFF;
  agu_mode_t mode_i = MODE_INDIRECT;
  agu_stack_t stack_op_i = STK_NONE;
  agu_push_t push_kind_i = PUSH_DATA;
  int num_errors = 0, tests_run = 0;
  agu_addr_gen dut (.*);
  agu_mem_model u_mem (.clk_i(clk_i), .we_i(ea_valid_o & push_q), .addr_i(ea_o),
    .wdata_i(push_word_o), .raddr_i(maddr), .rdata_o(mem_q));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) push_q <= (stack_op_i == STK_PUSH);
  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic ww(input logic [3:0] i, input logic [15:0] d);
    @(posedge clk_i);
    default_working_reg_we_i <= 1'h1;
    default_working_reg_idx_i <= i;
    default_working_reg_data_i <= d;
    @(posedge clk_i);
    default_working_reg_we_i <= 1'h0;
  endtask
  // One request; outputs are looked at in the single cycle they stand
  task automatic go(input agu_mode_t m, input logic [3:0] p, input logic [15:0] l,
    input logic [3:0] o = 4'h0, input agu_stack_t s = STK_NONE,
    input agu_push_t k = PUSH_DATA, input logic mc = 1'h0, input logic ys = 1'h0);
    @(posedge clk_i);
    req_i <= (s == STK_NONE);
    stack_op_i <= s;
    push_kind_i <= k;
    mode_i <= m;
    ptr_i <= p;
    lit_i <= l;
    off_reg_i <= o;
    base_operand_reg_i <= o;
    mac_i <= mc;
    y_space_i <= ys;
    push_data_i <= l;
    lit5_i <= l[4:0];
    branch_lit_i <= l;
    interrupt_disable_instr_lit_i <= l[13:0];
    @(posedge clk_i);
    req_i <= 1'h0;
    stack_op_i <= STK_NONE;
    #1;
  endtask
  task automatic ce(input logic [15:0] a, input logic e = 1'h0);
    chk(16'(ea_valid_o), 16'h0001);
    chk(ea_o, a);
    chk(16'(stack_error_o), 16'(e));
  endtask
  task automatic t_regs;
    for (int a = 0; a < 20; a += 4) begin
      apb(1'h0, 8'(a), 32'h0);
      chk(rd[15:0], `AGU_BOUND_RST);
    end
    apb(1'h1, `AGU_OFF_CTRL, 32'hFFFFFFFF);
    apb(1'h0, `AGU_OFF_CTRL, 32'h0);
    chk(rd[31:16], 16'h0000);
    chk(rd[15:0], 16'hFFFF);
    apb(1'h1, `AGU_OFF_SPLIMIT, 32'h1FFF);
    apb(1'h0, `AGU_OFF_SPLIMIT, 32'h0);
    chk(rd[15:0], 16'h1FFE);
    apb(1'h0, 8'h40, 32'h0);
    chk(16'(err), 16'h0001);
    ww(4'hF, 16'h1000);
    apb(1'h1, `AGU_OFF_SP, 32'h5555);
    apb(1'h0, `AGU_OFF_SP, 32'h0);
    chk(rd[15:0], 16'h1000);
  endtask
  task automatic t_stack;
    apb(1'h1, `AGU_OFF_SPLIMIT, 32'h1002);
    ww(4'h2, 16'h0010);
    go(MODE_INDIRECT, 4'hF, 16'hA001, 4'h0, STK_PUSH);
    ce(16'h1000);
    go(MODE_INDIRECT, 4'hF, 16'hA002, 4'h0, STK_PUSH);
    ce(16'h1002);
    go(MODE_INDIRECT, 4'hF, 16'hA003, 4'h0, STK_PUSH);
    ce(16'h1004, 1'h1);
    go(MODE_INDIRECT, 4'hF, 16'h0, 4'h0, STK_POP);
    ce(16'h1004, 1'h1);
    maddr = 16'h1000;
    #1 chk(mem_q, 16'hA001);
    go(MODE_INDIRECT, 4'hF, 16'h0, 4'h0, STK_PUSH, PUSH_CALL_HI);
    chk(push_word_o, 16'h007F);
    go(MODE_INDIRECT, 4'hF, 16'h0, 4'h0, STK_PUSH, PUSH_EXC_HI);
    chk(push_word_o, 16'hA57F);
    ww(4'hF, 16'h07FE);
    go(MODE_INDIRECT, 4'hF, 16'h0, 4'h0, STK_PUSH);
    ce(16'h07FE, 1'h1);
    ww(4'hF, 16'h0800);
    go(MODE_INDIRECT, 4'hF, 16'h0, 4'h0, STK_PUSH);
    ce(16'h0800);
  endtask
  task automatic t_modes;
    ww(4'h1, 16'h2000);
    go(MODE_POST, 4'h1, 16'hFFFE);
    ce(16'h2000);
    chk(16'(dst_w0_o), 16'h0000);
    go(MODE_INDIRECT, 4'h1, 16'h0);
    ce(16'h1FFE);
    go(MODE_PRE, 4'h1, 16'h0004);
    ce(16'h2002);
    go(MODE_REG_OFF, 4'h1, 16'h0, 4'h2);
    ce(16'h2012);
    chk(op1_o, 16'h0010);
    go(MODE_LIT_OFF, 4'h1, 16'h0006);
    ce(16'h2008);
    chk(op2_o, 16'h0006);
    chk(branch_off_o, 16'h0006);
    chk(16'(interrupt_disable_instr_count_o), 16'h0006);
    go(MODE_FILE, 4'h1, 16'hFFFF);
    ce(16'h1FFF);
    chk(16'(dst_w0_o), 16'h0001);
  endtask
  task automatic t_circ;
    apb(1'h1, `AGU_OFF_XSTART, 32'h1000);
    apb(1'h1, `AGU_OFF_XEND, 32'h100E);
    apb(1'h1, `AGU_OFF_CTRL, 32'h80F3);
    ww(4'h3, 16'h100E);
    go(MODE_POST, 4'h3, 16'h0004);
    ce(16'h100E);
    go(MODE_PRE, 4'h3, 16'hFFFA);
    ce(16'h100C);
    go(MODE_LIT_OFF, 4'h3, 16'h0004);
    ce(16'h1000);
    go(MODE_INDIRECT, 4'h3, 16'h0);
    ce(16'h100C);
    apb(1'h1, `AGU_OFF_CTRL, 32'h00F3);
    go(MODE_LIT_OFF, 4'h3, 16'h0004);
    ce(16'h1010);
    apb(1'h1, `AGU_OFF_YSTART, 32'h1000);
    apb(1'h1, `AGU_OFF_YEND, 32'h100E);
    apb(1'h1, `AGU_OFF_CTRL, 32'h4035);
    go(MODE_LIT_OFF, 4'h3, 16'h0004, 4'h0, STK_NONE, PUSH_DATA, 1'h0, 1'h1);
    ce(16'h1000);
    go(MODE_LIT_OFF, 4'h3, 16'h0004);
    ce(16'h1010);
    ww(4'h3, 16'h1005);
    go(MODE_INDIRECT, 4'h3, 16'h0, 4'h0, STK_NONE, PUSH_DATA, 1'h0, 1'h1);
    ce(16'h1004);
  endtask
  task automatic t_mac;
    ww(4'h8, 16'h3000);
    ww(4'hA, 16'h4000);
    go(MODE_POST, 4'h8, 16'h0006, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    ce(16'h3000);
    chk(16'(ea_y_space_o), 16'h0000);
    go(MODE_INDIRECT, 4'hA, 16'h0, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    chk(16'(ea_y_space_o), 16'h0001);
    go(MODE_REG_OFF, 4'h9, 16'h0, 4'h2, STK_NONE, PUSH_DATA, 1'h1);
    chk(16'(mac_illegal_o), 16'h0000);
    go(MODE_POST, 4'h8, 16'h0008, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    chk(16'(mac_illegal_o), 16'h0001);
    go(MODE_INDIRECT, 4'h8, 16'h0, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    ce(16'h3006);
    go(MODE_LIT_OFF, 4'h8, 16'h0002, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    chk(16'(mac_illegal_o), 16'h0001);
    go(MODE_INDIRECT, 4'h1, 16'h0, 4'h0, STK_NONE, PUSH_DATA, 1'h1);
    chk(16'(ea_valid_o), 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    t_regs();
    t_stack();
    t_modes();
    t_circ();
    t_mac();
    end_of_test();
  end
  // The tests need well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
